/* File: rtl/rdd_pkg.sv */
// Constants, carriers and state types of the receive descrambler/destuffer
package rdd_pkg;

  // Octet values of the framing
  localparam logic [7:0] RDD_FLAG_OCTET = 8'h7E;
  localparam logic [7:0] RDD_ESC_OCTET = 8'h7D;
  localparam logic [7:0] RDD_ESC_XOR = 8'h20;

  // Descrambler and FCS geometry
  localparam int RDD_SCR_TAP = 43;
  localparam int RDD_LINE_DEPTH = 4;
  localparam logic [2:0] RDD_FCS16_LEN = 3'h2;
  localparam logic [2:0] RDD_FCS32_LEN = 3'h4;

  // Register map, byte addresses
  localparam int RDD_ADDR_W = 8;
  localparam logic [7:0] RDD_CTRL_ADDR = 8'h00;
  localparam logic [7:0] RDD_ISTAT_ADDR = 8'h04;
  localparam logic [7:0] RDD_IMASK_ADDR = 8'h08;
  localparam logic [7:0] RDD_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] RDD_ERRCNT_ADDR = 8'h10;

  // Control fields
  localparam int RDD_CTRL_W = 3;
  localparam int RDD_CTRL_DESCR_BIT = 0;
  localparam int RDD_CTRL_FCS32_BIT = 1;
  localparam int RDD_CTRL_CLEAR_BIT = 2;
  localparam logic [2:0] RDD_CTRL_RESET = 3'h0;

  // Event bits of status and mask
  localparam int RDD_EV_W = 2;
  localparam int RDD_EV_TRANSP_BIT = 0;
  localparam int RDD_EV_ABORT_BIT = 1;

  // AXI responses
  localparam logic [1:0] RDD_RESP_OKAY = 2'h0;
  localparam logic [1:0] RDD_RESP_SLVERR = 2'h2;

  // One processed byte with its markers
  typedef struct packed {
    logic valid;
    logic flag;
    logic fcs;
    logic bad;
    logic [7:0] data;
  } rdd_byte_type;

  // Descrambler state
  typedef struct packed {
    logic [RDD_SCR_TAP-1:0] hist;
    logic out_valid;
    logic [7:0] out_byte;
  } rdd_dsc_state_type;

  // Top-level state
  typedef struct packed {
    logic [7:0] sync1_byte;
    logic [7:0] sync2_byte;
    logic sync1_stb;
    logic sync2_stb;
    logic esc;
    logic frame_err;
    rdd_byte_type [RDD_LINE_DEPTH-1:0] line;
    rdd_byte_type out;
    logic [RDD_CTRL_W-1:0] ctrl;
    logic [RDD_EV_W-1:0] istat;
    logic [RDD_EV_W-1:0] imask;
    logic [15:0] errcnt;
    logic irq;
    logic aw_rdy;
    logic [RDD_ADDR_W-1:0] aw_addr;
    logic w_rdy;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rdd_state_type;

  localparam rdd_state_type RDD_STATE_RESET = '{
    aw_rdy: 1'b1,
    w_rdy: 1'b1,
    ar_rdy: 1'b1,
    default: '0
  };

endpackage : rdd_pkg

/* File: rtl/rdd_descrambler.sv */
// Self-synchronising x^43+1 byte descrambler
`timescale 1ns/1ps
module rdd_descrambler
  import rdd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hard_reset,
  input wire logic clear,
  input wire logic enable,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic out_valid,
  output logic [7:0] out_byte
);

  rdd_dsc_state_type s_q;
  rdd_dsc_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [RDD_SCR_TAP-1:0] h;
    logic b;
    h = s_q.hist;
    b = 1'b0;
    s_d = s_q;
    s_d.out_valid = in_valid;
    if (in_valid) begin
      // MSB first; history holds received bits
      for (int i = 7; i >= 0; i--) begin
        b = in_byte[i];
        s_d.out_byte[i] = enable ? (b ^ h[RDD_SCR_TAP-1]) : b;
        h = {h[RDD_SCR_TAP-2:0], b};
      end
      s_d.hist = h;
    end
    if (clear) begin
      s_d = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk or posedge hard_reset) begin
    if (hard_reset) begin
      s_q <= '0;
    end else if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_valid = s_q.out_valid;
  assign out_byte = s_q.out_byte;

endmodule : rdd_descrambler

/* File: rtl/rdd_top.sv */
// Receive front end: descramble, destuff, flag and FCS tagging, AXI regs
//
// Contract
// - A PHY byte is taken only on a clock where its valid strobe is high.
// - Every PHY byte passes the descrambler before any other processing.
// - The descrambler implements the polynomial x^43 + 1.
// - Descrambling happens only while descramble_on is high, else bypass.
// - Each escape octet is deleted and the next byte, unless a flag or escape, is XORed to restore it.
// - Transparency errors in the escape sequence are detected and reported.
// - A frame ending in escape then closing flag is flagged as erroneous.
// - FCS bytes are located and marked with an extra identification bit.
// - Output bytes carry a valid qualifier plus flag and FCS marker bits.
// - The active-high hardware reset clears state asynchronously.
// - While the synchronous clear is high the block returns to idle.
`timescale 1ns/1ps
module rdd_top
  import rdd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hard_reset,
  input wire logic [7:0] phy_rx_byte,
  input wire logic phy_rx_strobe,
  input wire logic [RDD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RDD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rdd_byte_type rx_out,
  output logic irq
);

  rdd_state_type s_q;
  rdd_state_type s_d;
  logic dsc_valid;
  logic [7:0] dsc_byte;
  logic descramble_on;
  logic sync_clear;

  assign descramble_on = s_q.ctrl[RDD_CTRL_DESCR_BIT];
  assign sync_clear = s_q.ctrl[RDD_CTRL_CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Descrambler sees the synchronised PHY byte first
  rdd_descrambler u_descrambler (
    .aclk(aclk),
    .aresetn(aresetn),
    .hard_reset(hard_reset),
    .clear(sync_clear),
    .enable(descramble_on),
    .in_valid(s_q.sync2_stb),
    .in_byte(s_q.sync2_byte),
    .out_valid(dsc_valid),
    .out_byte(dsc_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdd_byte_type new_ent;
    rdd_byte_type [RDD_LINE_DEPTH-1:0] line_m;
    logic push;
    logic blocked;
    logic [2:0] fcs_len;
    logic [RDD_EV_W-1:0] ev;
    logic [RDD_EV_W-1:0] w1c;
    logic [31:0] rd;
    logic [1:0] rr;
    new_ent = '0;
    line_m = s_q.line;
    push = 1'b0;
    blocked = 1'b0;
    fcs_len = s_q.ctrl[RDD_CTRL_FCS32_BIT] ? RDD_FCS32_LEN : RDD_FCS16_LEN;
    ev = '0;
    w1c = '0;
    rd = 32'h0;
    rr = RDD_RESP_OKAY;
    s_d = s_q;

    // Pin synchroniser; strobe travels with its byte
    s_d.sync1_byte = phy_rx_byte;
    s_d.sync1_stb = phy_rx_strobe;
    s_d.sync2_byte = s_q.sync1_byte;
    s_d.sync2_stb = s_q.sync1_stb;
    s_d.out.valid = 1'b0;

    // Escape removal and error detection
    if (dsc_valid) begin
      if (s_q.esc) begin
        s_d.esc = 1'b0;
        if (dsc_byte == RDD_FLAG_OCTET) begin
          // Escape then flag closes a broken frame
          ev[RDD_EV_ABORT_BIT] = 1'b1;
          new_ent.flag = 1'b1;
          new_ent.bad = 1'b1;
          new_ent.data = dsc_byte;
          s_d.frame_err = 1'b0;
          push = 1'b1;
        end else if (dsc_byte == RDD_ESC_OCTET) begin
          // Double escape: drop first, keep second pending
          ev[RDD_EV_TRANSP_BIT] = 1'b1;
          s_d.frame_err = 1'b1;
          s_d.esc = 1'b1;
        end else begin
          new_ent.data = dsc_byte ^ RDD_ESC_XOR;
          push = 1'b1;
        end
      end else if (dsc_byte == RDD_ESC_OCTET) begin
        s_d.esc = 1'b1;
      end else if (dsc_byte == RDD_FLAG_OCTET) begin
        new_ent.flag = 1'b1;
        new_ent.bad = s_q.frame_err;
        new_ent.data = dsc_byte;
        s_d.frame_err = 1'b0;
        push = 1'b1;
      end else begin
        new_ent.data = dsc_byte;
        push = 1'b1;
      end
    end

    // Delay line: a flag marks the bytes just ahead of it as FCS
    if (push) begin
      new_ent.valid = 1'b1;
      if (new_ent.flag) begin
        for (int i = 0; i < RDD_LINE_DEPTH; i++) begin
          if (line_m[i].valid && line_m[i].flag) begin
            blocked = 1'b1;
          end
          if (!blocked && line_m[i].valid && (i < int'(fcs_len))) begin
            line_m[i].fcs = 1'b1;
          end
        end
      end
      s_d.out = line_m[RDD_LINE_DEPTH-1];
      s_d.line = {line_m[RDD_LINE_DEPTH-2:0], new_ent};
    end

    if (|ev) begin
      s_d.errcnt = s_q.errcnt + 16'h1;
    end

    // AXI write: address and data taken in either order
    if (s_q.aw_rdy && s_axi_awvalid) begin
      s_d.aw_rdy = 1'b0;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.w_rdy && s_axi_wvalid) begin
      s_d.w_rdy = 1'b0;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (!s_q.aw_rdy && !s_q.w_rdy && !s_q.bvalid) begin
      s_d.bvalid = 1'b1;
      s_d.aw_rdy = 1'b1;
      s_d.w_rdy = 1'b1;
      s_d.bresp = RDD_RESP_OKAY;
      case (s_q.aw_addr)
        RDD_CTRL_ADDR: begin
          if (s_q.w_strb[0]) begin
            s_d.ctrl = s_q.w_data[RDD_CTRL_W-1:0];
          end
        end
        RDD_ISTAT_ADDR: begin
          if (s_q.w_strb[0]) begin
            w1c = s_q.w_data[RDD_EV_W-1:0];
          end
        end
        RDD_IMASK_ADDR: begin
          if (s_q.w_strb[0]) begin
            s_d.imask = s_q.w_data[RDD_EV_W-1:0];
          end
        end
        RDD_STATUS_ADDR, RDD_ERRCNT_ADDR: begin
          s_d.bresp = RDD_RESP_OKAY;
        end
        default: begin
          s_d.bresp = RDD_RESP_SLVERR;
        end
      endcase
    end

    // Set wins over write-one-to-clear
    s_d.istat = (s_q.istat & ~w1c) | ev;

    // AXI read
    case (s_axi_araddr)
      RDD_CTRL_ADDR: rd = {29'h0, s_q.ctrl};
      RDD_ISTAT_ADDR: rd = {30'h0, s_q.istat};
      RDD_IMASK_ADDR: rd = {30'h0, s_q.imask};
      RDD_STATUS_ADDR: rd = {30'h0, s_q.frame_err, s_q.esc};
      RDD_ERRCNT_ADDR: rd = {16'h0, s_q.errcnt};
      default: rr = RDD_RESP_SLVERR;
    endcase
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.ar_rdy = 1'b1;
    end
    if (s_q.ar_rdy && s_axi_arvalid) begin
      s_d.ar_rdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rr;
    end

    // Synchronous clear returns the datapath to idle
    if (sync_clear) begin
      s_d.sync1_byte = 8'h00;
      s_d.sync2_byte = 8'h00;
      s_d.sync1_stb = 1'b0;
      s_d.sync2_stb = 1'b0;
      s_d.esc = 1'b0;
      s_d.frame_err = 1'b0;
      s_d.line = '0;
      s_d.out = '0;
    end

    s_d.irq = |(s_d.istat & s_d.imask);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk or posedge hard_reset) begin
    if (hard_reset) begin
      s_q <= RDD_STATE_RESET;
    end else if (!aresetn) begin
      s_q <= RDD_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign rx_out = s_q.out;
  assign irq = s_q.irq;

endmodule : rdd_top

/* File: bench/rdd_phy_model.sv */
// Behavioural PHY framer: scrambled octets, one idle gap after each
`timescale 1ns/1ps
module rdd_phy_model (
  input wire logic aclk,
  input wire logic scr,
  output logic [7:0] phy_rx_byte,
  output logic phy_rx_strobe
);
  logic [42:0] hist = '0;
  initial begin
    phy_rx_byte = 8'h00;
    phy_rx_strobe = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [7:0] o;
    for (int i = 7; i >= 0; i--) begin
      o[i] = b[i] ^ (scr & hist[42]);
      hist = {hist[41:0], o[i]};
    end
    @(posedge aclk);
    phy_rx_byte <= o;
    phy_rx_strobe <= 1'b1;
    @(posedge aclk);
    // Idle byte differs so a missed strobe check shows
    phy_rx_byte <= ~o;
    phy_rx_strobe <= 1'b0;
  endtask : send
endmodule : rdd_phy_model

/* File: bench/rdd_top_checker.sv */
// Port-level assertions for the receive front end
`timescale 1ns/1ps
module rdd_top_checker
  import rdd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hard_reset,
  input wire logic phy_rx_strobe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire rdd_byte_type rx_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || hard_reset);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid;
  endsequence
  sequence wr_done;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_wr_answer: assert property (wr_taken |=> wr_done)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_no_strobe: assert property (!phy_rx_strobe [*6] |=> !rx_out.valid)
    else $error("output without input byte");
  a_flag_octet: assert property (rx_out.valid && rx_out.flag |->
    rx_out.data == RDD_FLAG_OCTET) else $error("flag mark on wrong octet");
  a_bad_on_flag: assert property (rx_out.valid && rx_out.bad |->
    rx_out.flag) else $error("bad mark off a flag");
  a_mark_excl: assert property (rx_out.valid |->
    !(rx_out.flag && rx_out.fcs)) else $error("flag marked as check byte");
endmodule : rdd_top_checker
bind rdd_top rdd_top_checker chk (.*);

/* File: bench/tb_rx_descrambler_destuffer.sv */
// Self-checking bench for the receive descrambler/destuffer
`timescale 1ns/1ps
module tb_rx_descrambler_destuffer
  import rdd_pkg::*;
;
  localparam logic [1:0] OK = RDD_RESP_OKAY;
  localparam logic [1:0] ERR = RDD_RESP_SLVERR;
  localparam logic [7:0] FR [14] = '{8'h11, 8'h7D, 8'h5E, 8'h22, 8'h33,
    8'h44, 8'h7E, 8'h55, 8'h7D, 8'h7E, 8'h7D, 8'h7D, 8'h66, 8'h7E};
  // Flag 400, check byte 200, bad 100, then data
  localparam logic [10:0] EX [10] = '{11'h011, 11'h07E, 11'h022, 11'h233,
    11'h244, 11'h47E, 11'h255, 11'h57E, 11'h246, 11'h57E};
  // Same frames with four check bytes in the first frame
  localparam logic [10:0] EX32 [10] = '{11'h011, 11'h27E, 11'h222, 11'h233,
    11'h244, 11'h47E, 11'h255, 11'h57E, 11'h246, 11'h57E};
  logic aclk, aresetn, hard_reset, scr, phy_rx_strobe, irq;
  logic [7:0] phy_rx_byte, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  rdd_byte_type rx_out;
  logic [10:0] got[$];
  int n_errors = 0;
  int comparisons = 0;
  int k;
  rdd_phy_model phy (.*);
  rdd_top uut (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (rx_out.valid === 1'b1) got.push_back(rx_out[10:0]);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : rd
  task automatic complete_run;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    aresetn = 1'b0;
    hard_reset = 1'b0;
    scr = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(RDD_CTRL_ADDR, 32'h0, OK);
    rd(RDD_ISTAT_ADDR, 32'h0, OK);
    // Pass 0 scrambled, pass 1 bypass, pass 2 bypass with four check bytes
    for (int p = 0; p < 3; p++) begin
      scr <= (p == 0);
      wr(RDD_CTRL_ADDR, {30'h0, p == 2, p == 0}, OK);
      repeat (5) phy.send(RDD_FLAG_OCTET);
      foreach (FR[i]) phy.send(FR[i]);
      repeat (5) phy.send(RDD_FLAG_OCTET);
      repeat (8) @(posedge aclk);
      k = 0;
      while (k < got.size() && (got[k] === 11'h47E || got[k] === 11'h0)) k++;
      foreach (EX[i]) begin
        chk({21'h0, got[k+i]}, {21'h0, (p == 2) ? EX32[i] : EX[i]});
      end
      got.delete();
    end
    rd(RDD_ISTAT_ADDR, 32'h3, OK);
    rd(RDD_ERRCNT_ADDR, 32'h6, OK);
    chk({31'h0, irq}, 32'h0);
    wr(RDD_IMASK_ADDR, 32'h1, OK);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(RDD_ISTAT_ADDR, 32'h1, OK);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(RDD_ISTAT_ADDR, 32'h2, OK);
    // Pending escape is dropped by the synchronous clear
    phy.send(RDD_ESC_OCTET);
    repeat (4) @(posedge aclk);
    rd(RDD_STATUS_ADDR, 32'h1, OK);
    wr(RDD_CTRL_ADDR, 32'h4, OK);
    rd(RDD_STATUS_ADDR, 32'h0, OK);
    wr(RDD_CTRL_ADDR, 32'h0, OK);
    rd(8'h14, 32'h0, ERR);
    wr(8'h14, 32'h1, ERR);
    @(posedge aclk);
    hard_reset <= 1'b1;
    @(posedge aclk);
    hard_reset <= 1'b0;
    rd(RDD_IMASK_ADDR, 32'h0, OK);
    complete_run;
  end
endmodule : tb_rx_descrambler_destuffer
